// File: verilog/eps_pkg.sv
// Purpose: constants for the ethernet port statistics bank
// Assumes: 100 MHz clock, 16-bit register data
// Notes:   register offsets are word indices on the plain register port
package eps_pkg;
	// ---------------------------------------------------------------
	// widths and timing
	// ---------------------------------------------------------------
	localparam int          CNT_W         = 16;
	localparam int          ADDR_W        = 8;
	localparam int          SOCKETS       = 32;
	localparam int          ROUTE_FIELDS  = 8;
	localparam int          COLL_LIMIT    = 16;
	localparam int          CLK_MHZ       = 100;
	localparam int          FAULT_TIME_MS = 1000;
	localparam int          FAULT_CYCLES  = FAULT_TIME_MS * 1000 * CLK_MHZ;
	localparam logic [7:0]  ROUTE_EMPTY   = 8'hFF;
	localparam logic [15:0] RESET_VALUE   = 16'h0000;

	// ---------------------------------------------------------------
	// counter indices, also their register offsets
	// ---------------------------------------------------------------
	localparam int C_GEN_PKT   = 0;
	localparam int C_ACK_SEG   = 1;
	localparam int C_ABORT     = 2;
	localparam int C_RETX      = 3;
	localparam int C_LRD       = 4;
	localparam int C_LWR       = 5;
	localparam int C_UNK_FRAME = 6;
	localparam int C_TX_FRAME  = 7;
	localparam int C_RX_FRAME  = 8;
	localparam int C_COLL      = 9;
	localparam int C_XCOLL     = 10;
	localparam int C_CKSUM     = 11;
	localparam int C_FRAMING   = 12;
	localparam int C_SEQ       = 13;
	localparam int NUM_CNT     = 14;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] A_OPEN_CONN   = 8'h10;
	localparam logic [7:0] A_CLIENT_CONN = 8'h11;
	localparam logic [7:0] A_QUEUE_DEPTH = 8'h12;
	localparam logic [7:0] A_BUF_USE     = 8'h13;
	localparam logic [7:0] A_CLEAR       = 8'h14;
	localparam logic [7:0] A_FAULT       = 8'h15;
	localparam logic [7:0] A_ROUTE_BASE  = 8'h20;
	localparam logic [7:0] A_SOCK_BASE   = 8'h40;
endpackage

// File: verilog/eps_stats.sv
// Purpose: statistics bank of the ethernet port
// Assumes: event strobes one cycle long, synchronous to clk_in
// Notes:   gauges and tables are loaded by the protocol engine
//
// Function
// - error advance lights fault pair one second
// - count internally generated packets
// - count acknowledged sent segments
// - timeout closes connection, counts aborts
// - count retransmitted segments
// - count local register reads
// - count local register writes
// - open connections live gauge
// - client connections live gauge
// - count unknown frame type packets
// - count transmitted frames
// - count received frames
// - eight route fields, empty marks, zero reset
// - route read not atomic
// - count collisions
// - queue depth live gauge
// - over sixteen collisions abandons, counts loss
// - checksum errors discarded and counted
// - framing errors discarded and counted
// - wrong sequence counted, reject reply sent
// - buffers in use live gauge
// - socket to IP address table
// - clear request zeroes all counters together
`timescale 1ns/10ps
`default_nettype none
module eps_stats (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// register port
	input  wire logic [7:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rdata_out,
	// engine events
	input  wire logic        gen_pkt_in,
	input  wire logic        ack_seg_in,
	input  wire logic        timeout_in,
	input  wire logic [4:0]  timeout_sock_in,
	input  wire logic        retx_in,
	input  wire logic        local_rd_in,
	input  wire logic        local_wr_in,
	input  wire logic        unk_frame_in,
	input  wire logic        tx_frame_in,
	input  wire logic        rx_frame_in,
	input  wire logic        coll_in,
	input  wire logic        tx_start_in,
	input  wire logic        cksum_err_in,
	input  wire logic        framing_err_in,
	input  wire logic        seq_err_in,
	input  wire logic [4:0]  seq_sock_in,
	// gauges
	input  wire logic [15:0] open_conn_in,
	input  wire logic [15:0] client_conn_in,
	input  wire logic [15:0] queue_depth_in,
	input  wire logic [15:0] buf_use_in,
	// route capture
	input  wire logic        route_valid_in,
	input  wire logic [3:0]  route_len_in,
	input  wire logic [63:0] route_in,
	// socket table loads
	input  wire logic        sock_wr_in,
	input  wire logic [4:0]  sock_idx_in,
	input  wire logic [31:0] sock_ip_in,
	// engine actions
	output logic             close_conn_out,
	output logic      [4:0]  close_sock_out,
	output logic             abandon_tx_out,
	output logic             discard_rx_out,
	output logic             seq_reject_out,
	output logic      [4:0]  seq_reject_sock_out,
	// fault lamps
	output logic             fault_red_out,
	output logic             fault_green_out
);
	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic [15:0] cnt [eps_pkg::NUM_CNT];
	logic [7:0]  route [eps_pkg::ROUTE_FIELDS];
	logic [31:0] sock_ip [eps_pkg::SOCKETS];
	logic [4:0]  coll_run;
	logic [31:0] fault_timer;
	logic        xcoll_ev;
	logic        err_ev;
	logic        clear_ev;
	logic [eps_pkg::NUM_CNT-1:0] ev;

	assign clear_ev = wr_in && (addr_in == eps_pkg::A_CLEAR) && wdata_in[0];
	// excess is the seventeenth collision on one packet
	assign xcoll_ev = coll_in && (coll_run == 5'(eps_pkg::COLL_LIMIT));

	always_comb begin
		ev = '0;
		ev[eps_pkg::C_GEN_PKT]   = gen_pkt_in;
		ev[eps_pkg::C_ACK_SEG]   = ack_seg_in;
		ev[eps_pkg::C_ABORT]     = timeout_in;
		ev[eps_pkg::C_RETX]      = retx_in;
		ev[eps_pkg::C_LRD]       = local_rd_in;
		ev[eps_pkg::C_LWR]       = local_wr_in;
		ev[eps_pkg::C_UNK_FRAME] = unk_frame_in;
		ev[eps_pkg::C_TX_FRAME]  = tx_frame_in;
		ev[eps_pkg::C_RX_FRAME]  = rx_frame_in;
		ev[eps_pkg::C_COLL]      = coll_in;
		ev[eps_pkg::C_XCOLL]     = xcoll_ev;
		ev[eps_pkg::C_CKSUM]     = cksum_err_in;
		ev[eps_pkg::C_FRAMING]   = framing_err_in;
		ev[eps_pkg::C_SEQ]       = seq_err_in;
	end

	assign err_ev = ev[eps_pkg::C_ABORT] | ev[eps_pkg::C_RETX] | ev[eps_pkg::C_UNK_FRAME]
		| ev[eps_pkg::C_COLL] | ev[eps_pkg::C_XCOLL] | ev[eps_pkg::C_CKSUM]
		| ev[eps_pkg::C_FRAMING] | ev[eps_pkg::C_SEQ];

	// ---------------------------------------------------------------
	// counters
	// ---------------------------------------------------------------
	// an event in the clear cycle is dropped with the rest: clear is a snapshot to zero
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < eps_pkg::NUM_CNT; i++) begin
			if (!nrst_in || clear_ev) begin
				cnt[i] <= eps_pkg::RESET_VALUE;
			end else if (ev[i]) begin
				cnt[i] <= cnt[i] + 16'h0001;
			end
		end
	end

	// per-packet collision run
	always_ff @(posedge clk_in) begin
		if (!nrst_in || tx_start_in || xcoll_ev) begin
			coll_run <= 5'h00;
		end else if (coll_in) begin
			coll_run <= coll_run + 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// engine actions
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			close_conn_out      <= 1'b0;
			close_sock_out      <= 5'h00;
			abandon_tx_out      <= 1'b0;
			discard_rx_out      <= 1'b0;
			seq_reject_out      <= 1'b0;
			seq_reject_sock_out <= 5'h00;
		end else begin
			close_conn_out <= timeout_in;
			if (timeout_in) begin
				close_sock_out <= timeout_sock_in;
			end
			abandon_tx_out <= xcoll_ev;
			discard_rx_out <= cksum_err_in | framing_err_in;
			seq_reject_out <= seq_err_in;
			if (seq_err_in) begin
				seq_reject_sock_out <= seq_sock_in;
			end
		end
	end

	// ---------------------------------------------------------------
	// fault lamps
	// ---------------------------------------------------------------
	// each new error restarts the full second
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			fault_timer <= 32'h00000000;
		end else if (err_ev) begin
			fault_timer <= 32'(eps_pkg::FAULT_CYCLES);
		end else if (fault_timer != 32'h00000000) begin
			fault_timer <= fault_timer - 32'h00000001;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			fault_red_out   <= 1'b0;
			fault_green_out <= 1'b0;
		end else begin
			fault_red_out   <= err_ev || (fault_timer > 32'h00000001);
			fault_green_out <= err_ev || (fault_timer > 32'h00000001);
		end
	end

	// ---------------------------------------------------------------
	// route record and socket table
	// ---------------------------------------------------------------
	// fields update in place; a reader between two fetches may mix routes
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < eps_pkg::ROUTE_FIELDS; i++) begin
			if (!nrst_in) begin
				route[i] <= 8'h00;
			end else if (route_valid_in) begin
				route[i] <= (4'(i) < route_len_in) ? route_in[i*8 +: 8]
					: eps_pkg::ROUTE_EMPTY;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		for (int i = 0; i < eps_pkg::SOCKETS; i++) begin
			if (!nrst_in) begin
				sock_ip[i] <= 32'h00000000;
			end else if (sock_wr_in && (sock_idx_in == 5'(i))) begin
				sock_ip[i] <= sock_ip_in;
			end
		end
	end

	// ---------------------------------------------------------------
	// register read port
	// ---------------------------------------------------------------
	logic [15:0] next_rdata;
	logic [7:0]  rel;

	always_comb begin
		next_rdata = 16'h0000;
		rel        = 8'h00;
		if (addr_in < 8'(eps_pkg::NUM_CNT)) begin
			next_rdata = cnt[addr_in[3:0]];
		end else if (addr_in == eps_pkg::A_OPEN_CONN) begin
			next_rdata = open_conn_in;
		end else if (addr_in == eps_pkg::A_CLIENT_CONN) begin
			next_rdata = client_conn_in;
		end else if (addr_in == eps_pkg::A_QUEUE_DEPTH) begin
			next_rdata = queue_depth_in;
		end else if (addr_in == eps_pkg::A_BUF_USE) begin
			next_rdata = buf_use_in;
		end else if (addr_in == eps_pkg::A_FAULT) begin
			next_rdata = {15'h0000, fault_red_out};
		end else if (addr_in >= eps_pkg::A_ROUTE_BASE
			&& addr_in < eps_pkg::A_ROUTE_BASE + 8'(eps_pkg::ROUTE_FIELDS)) begin
			rel        = addr_in - eps_pkg::A_ROUTE_BASE;
			next_rdata = {8'h00, route[rel[2:0]]};
		end else if (addr_in >= eps_pkg::A_SOCK_BASE
			&& addr_in < eps_pkg::A_SOCK_BASE + 8'(2 * eps_pkg::SOCKETS)) begin
			rel        = addr_in - eps_pkg::A_SOCK_BASE;
			next_rdata = rel[0] ? sock_ip[rel[5:1]][15:0]
				: sock_ip[rel[5:1]][31:16];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			rdata_out <= 16'h0000;
		end else if (rd_in) begin
			rdata_out <= next_rdata;
		end else begin
			rdata_out <= 16'h0000;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_wrap;
		@(posedge clk_in) disable iff (!nrst_in)
		(ev[eps_pkg::C_TX_FRAME] && !clear_ev) |=> cnt[eps_pkg::C_TX_FRAME]
			== $past(cnt[eps_pkg::C_TX_FRAME]) + 16'h0001;
	endproperty
	a_wrap: assert property (p_wrap) else $error("frame counter missed step");

	property p_clear;
		@(posedge clk_in) disable iff (!nrst_in)
		clear_ev |=> (cnt[eps_pkg::C_SEQ] == 16'h0000) && (cnt[eps_pkg::C_GEN_PKT] == 16'h0000);
	endproperty
	a_clear: assert property (p_clear) else $error("clear left a counter");

	property p_fault;
		@(posedge clk_in) disable iff (!nrst_in)
		err_ev |=> (fault_red_out && fault_green_out) [*8];
	endproperty
	a_fault: assert property (p_fault) else $error("fault lamps not lit");

	property p_close;
		@(posedge clk_in) disable iff (!nrst_in)
		timeout_in |=> close_conn_out && close_sock_out == $past(timeout_sock_in);
	endproperty
	a_close: assert property (p_close) else $error("timeout did not close");

	property p_reject;
		@(posedge clk_in) disable iff (!nrst_in)
		seq_err_in |=> seq_reject_out && seq_reject_sock_out == $past(seq_sock_in);
	endproperty
	a_reject: assert property (p_reject) else $error("no sequence reject");

	property p_xcoll;
		@(posedge clk_in) disable iff (!nrst_in)
		abandon_tx_out |-> $past(coll_run) == 5'(eps_pkg::COLL_LIMIT);
	endproperty
	a_xcoll: assert property (p_xcoll) else $error("early abandon");

	property p_discard;
		@(posedge clk_in) disable iff (!nrst_in)
		(cksum_err_in || framing_err_in) |=> discard_rx_out;
	endproperty
	a_discard: assert property (p_discard) else $error("bad packet kept");

	property p_route;
		@(posedge clk_in) disable iff (!nrst_in)
		(route_valid_in && route_len_in == 4'h0) |=> route[0] == eps_pkg::ROUTE_EMPTY
			&& route[7] == eps_pkg::ROUTE_EMPTY;
	endproperty
	a_route: assert property (p_route) else $error("empty route not marked");

	property p_rd_idle;
		@(posedge clk_in) disable iff (!nrst_in)
		!rd_in |=> rdata_out == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

	property p_open;
		@(posedge clk_in) disable iff (!nrst_in)
		(rd_in && addr_in == eps_pkg::A_OPEN_CONN) |=> rdata_out == $past(open_conn_in);
	endproperty
	a_open: assert property (p_open) else $error("open gauge misread");

	property p_client;
		@(posedge clk_in) disable iff (!nrst_in)
		(rd_in && addr_in == eps_pkg::A_CLIENT_CONN) |=> rdata_out == $past(client_conn_in);
	endproperty
	a_client: assert property (p_client) else $error("client gauge misread");

	property p_queue;
		@(posedge clk_in) disable iff (!nrst_in)
		(rd_in && addr_in == eps_pkg::A_QUEUE_DEPTH) |=> rdata_out == $past(queue_depth_in);
	endproperty
	a_queue: assert property (p_queue) else $error("queue gauge misread");

	property p_buf;
		@(posedge clk_in) disable iff (!nrst_in)
		(rd_in && addr_in == eps_pkg::A_BUF_USE) |=> rdata_out == $past(buf_use_in);
	endproperty
	a_buf: assert property (p_buf) else $error("buffer gauge misread");

	property p_lamp_pair;
		@(posedge clk_in) disable iff (!nrst_in)
		fault_red_out == fault_green_out;
	endproperty
	a_lamp_pair: assert property (p_lamp_pair) else $error("fault lamps differ");

	property p_gen_step;
		@(posedge clk_in) disable iff (!nrst_in)
		(gen_pkt_in && !clear_ev) |=> cnt[eps_pkg::C_GEN_PKT]
			== $past(cnt[eps_pkg::C_GEN_PKT]) + 16'h0001;
	endproperty
	a_gen_step: assert property (p_gen_step) else $error("generated count missed");

	property p_discard_frame;
		@(posedge clk_in) disable iff (!nrst_in)
		framing_err_in |=> discard_rx_out;
	endproperty
	a_discard_frame: assert property (p_discard_frame) else $error("bad frame kept");

	property p_route_full;
		@(posedge clk_in) disable iff (!nrst_in)
		(route_valid_in && route_len_in == 4'h8) |=> route[7] == $past(route_in[63:56]);
	endproperty
	a_route_full: assert property (p_route_full) else $error("last drop lost");

	sequence s_coll_limit;
		coll_in && coll_run == 5'(eps_pkg::COLL_LIMIT);
	endsequence

	sequence s_abandon;
		abandon_tx_out && coll_run == 5'h00;
	endsequence

	property p_xcoll_fire;
		@(posedge clk_in) disable iff (!nrst_in)
		s_coll_limit |=> s_abandon;
	endproperty
	a_xcoll_fire: assert property (p_xcoll_fire) else $error("excess not abandoned");

	sequence s_clear_gap;
		clear_ev ##1 (ev == '0) ##1 (rd_in && addr_in < 8'(eps_pkg::NUM_CNT));
	endsequence

	property p_clear_read;
		@(posedge clk_in) disable iff (!nrst_in)
		s_clear_gap |=> rdata_out == 16'h0000;
	endproperty
	a_clear_read: assert property (p_clear_read) else $error("counter read after clear");
endmodule
`default_nettype wire

// File: verification/eps_engine_model.sv
// Purpose: far-side engine model raising event strobes
// Assumes: bench hands one-hot request masks
// Notes:   strobes follow the mask with no delay
`timescale 1ns/10ps
`default_nettype none
module eps_engine_model (
	// requests from the bench
	input  wire logic [13:0] fire_in,
	input  wire logic [4:0]  sock_in,
	// event strobes
	output logic             gen_pkt_out,
	output logic             ack_seg_out,
	output logic             timeout_out,
	output logic             retx_out,
	output logic             local_rd_out,
	output logic             local_wr_out,
	output logic             unk_frame_out,
	output logic             tx_frame_out,
	output logic             rx_frame_out,
	output logic             coll_out,
	output logic             tx_start_out,
	output logic             cksum_err_out,
	output logic             framing_err_out,
	output logic             seq_err_out,
	output logic      [4:0]  sock_out
);
	assign {seq_err_out, framing_err_out, cksum_err_out, tx_start_out, coll_out,
		rx_frame_out, tx_frame_out, unk_frame_out, local_wr_out, local_rd_out,
		retx_out, timeout_out, ack_seg_out, gen_pkt_out} = fire_in;
	// one socket qualifies both timeout and sequence events
	assign sock_out = sock_in;
endmodule
`default_nettype wire

// File: verification/eps_stats_bench.sv
// Purpose: self-checking bench for the statistics bank
// Assumes: reads answer exactly one cycle after the strobe
// Notes:   lamps stay lit from the first error to the end of the run, the hold is too long
`timescale 1ns/10ps
`default_nettype none
module eps_stats_bench;
	logic        clk_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [15:0] wdata_in = 16'h0000;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        rd_seen = 1'b0;
	logic [13:0] fire = 14'h0000;
	logic [4:0]  sock_sel = 5'h00;
	logic [15:0] g [4] = '{default: 16'h0000};
	logic        rv = 1'b0;
	logic [3:0]  rlen = 4'h0;
	logic [63:0] rfld = 64'h0;
	logic        swr = 1'b0;
	logic [4:0]  sidx = 5'h00;
	logic [31:0] sip = 32'h0;
	wire logic [13:0] ev;
	wire logic [4:0]  es;
	wire logic [15:0] rdata_out;
	wire logic [4:0]  csock;
	wire logic [4:0]  rsock;
	wire logic        cc, ab, dr, sr, red, grn;
	logic [15:0] exp_q [$];
	int          cnt [14];
	int          mismatches = 0;
	int          checks_done = 0;
	int          lens [3] = '{3, 0, 8};
	int          calm [6] = '{0, 1, 4, 5, 7, 8};
	logic [63:0] v64;
	logic [15:0] v;

	always #5 clk_in = ~clk_in;

	eps_engine_model partner (.fire_in(fire), .sock_in(sock_sel), .gen_pkt_out(ev[0]),
		.ack_seg_out(ev[1]), .timeout_out(ev[2]), .retx_out(ev[3]), .local_rd_out(ev[4]),
		.local_wr_out(ev[5]), .unk_frame_out(ev[6]), .tx_frame_out(ev[7]),
		.rx_frame_out(ev[8]), .coll_out(ev[9]), .tx_start_out(ev[10]),
		.cksum_err_out(ev[11]), .framing_err_out(ev[12]), .seq_err_out(ev[13]),
		.sock_out(es));

	eps_stats dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.gen_pkt_in(ev[0]), .ack_seg_in(ev[1]), .timeout_in(ev[2]),
		.timeout_sock_in(es), .retx_in(ev[3]), .local_rd_in(ev[4]),
		.local_wr_in(ev[5]), .unk_frame_in(ev[6]), .tx_frame_in(ev[7]),
		.rx_frame_in(ev[8]), .coll_in(ev[9]), .tx_start_in(ev[10]),
		.cksum_err_in(ev[11]), .framing_err_in(ev[12]), .seq_err_in(ev[13]),
		.seq_sock_in(es), .open_conn_in(g[0]), .client_conn_in(g[1]),
		.queue_depth_in(g[2]), .buf_use_in(g[3]), .route_valid_in(rv),
		.route_len_in(rlen), .route_in(rfld), .sock_wr_in(swr), .sock_idx_in(sidx),
		.sock_ip_in(sip), .close_conn_out(cc), .close_sock_out(csock),
		.abandon_tx_out(ab), .discard_rx_out(dr), .seq_reject_out(sr),
		.seq_reject_sock_out(rsock), .fault_red_out(red), .fault_green_out(grn));

	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		checks_done++;
		if (seen !== expv) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		exp_q.push_back(e);
		@(posedge clk_in);
		rd_in <= 1'b0;
	endtask

	// strobe held n cycles counts once per cycle
	task automatic fire_n(input int idx, input int n);
		@(posedge clk_in);
		fire <= 14'h0001 << idx;
		repeat (n) @(posedge clk_in);
		fire <= 14'h0000;
		if (idx != 10) cnt[idx] = (cnt[idx] + n) % 65536;
	endtask

	task automatic read_counters;
		for (int i = 0; i < 14; i++) rd(8'(i), 16'(cnt[i]));
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_in) rd_seen <= rd_in;
	always @(negedge clk_in) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) check(16'hFFFF, 16'h0000);
			else check(rdata_out, exp_q.pop_front());
		end
	end

	initial begin
		#900000;
		mismatches++;
		final_report();
	end

	initial begin
		void'($urandom(32'h08B8));
		foreach (cnt[i]) cnt[i] = 0;
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		read_counters();
		rd(8'h20, 16'h0000);
		rd(8'hFF, 16'h0000);
		// ordinary traffic must leave the lamps dark
		foreach (calm[k]) fire_n(calm[k], 1 + $urandom_range(2));
		#1 check({15'h0, red}, 16'h0000);
		@(posedge clk_in);
		sock_sel <= 5'(1 + $urandom_range(30));
		fire_n(2, 1);
		#1 check({10'h0, cc, csock}, {10'h0, 1'b1, sock_sel});
		fire_n(13, 1);
		#1 check({10'h0, sr, rsock}, {10'h0, 1'b1, sock_sel});
		fire_n(11, 1);
		#1 check({15'h0, dr}, 16'h0001);
		fire_n(12, 2);
		#1 check({15'h0, dr}, 16'h0001);
		fire_n(3, 2);
		fire_n(10, 1);
		fire_n(9, 16);
		#1 check({15'h0, ab}, 16'h0000);
		fire_n(9, 1);
		#1 check({15'h0, ab}, 16'h0001);
		cnt[10] = 1;
		check({14'h0, red, grn}, 16'h0003);
		read_counters();
		rd(8'h15, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			v = 16'($urandom);
			g[i] <= v;
			rd(8'h10 + 8'(i), v);
		end
		foreach (lens[k]) begin
			v64 = {$urandom, $urandom};
			@(posedge clk_in);
			rfld <= v64;
			rlen <= 4'(lens[k]);
			rv <= 1'b1;
			@(posedge clk_in);
			rv <= 1'b0;
			for (int i = 0; i < 8; i++)
				rd(8'h20 + 8'(i), (i < lens[k]) ? {8'h00, v64[8*i+:8]} : 16'h00FF);
		end
		v64[31:0] = $urandom;
		@(posedge clk_in);
		sidx <= 5'($urandom_range(31));
		sip <= v64[31:0];
		swr <= 1'b1;
		@(posedge clk_in);
		swr <= 1'b0;
		rd(8'h40 + {2'b00, sidx, 1'b0}, v64[31:16]);
		rd(8'h41 + {2'b00, sidx, 1'b0}, v64[15:0]);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= 8'h14;
		wdata_in <= 16'h0001;
		@(posedge clk_in);
		wr_in <= 1'b0;
		foreach (cnt[i]) cnt[i] = 0;
		read_counters();
		fire_n(0, 65537);
		rd(8'h00, 16'h0001);
		repeat (2) @(posedge clk_in);
		final_report();
	end
endmodule
`default_nettype wire
